/* File: rtl/psv_pkg.sv */
// constants for the power state and voltage slew controller
// assumes one 200 MHz clock and synchronous command strobes from the link decoders
//
// How it works
// - sixteen fast slew rates from 10 to 95 mV/us are picked by a four-bit setting.
// - a second setting divides the fast rate by 2, 4, 8 or 16.
// - an upward ramp with load line positioning adds a correction built from capacitance and bandwidth terms.
// - states are full power, light load, active and passive discontinuous, and near off.
// - states change on a bus command, a serial ID command, a serial clock toggle, a current limit, or by themselves in auto mode.
// - only a serial ID command can enter the near off state.
// - an efficiency hint write is acknowledged and its payload stored.
// - the stored hints never reach the regulation outputs.
// - light load is entered only by command, never autonomously while phase shedding is on.
// - in command mode light load and the discontinuous states return to full power on command, voltage change or current limit.
// - in auto mode discontinuous states fall back to full power on high frequency, voltage change or current limit.
// - near off exits on a serial clock toggle in single rail mode or a set voltage command in multi rail mode.
// - entering near off acknowledges, ramps or decays the output to zero, and tristates all phases.
// - auto mode enters a discontinuous state when single phase current drops below a threshold.
package psv_pkg;
  typedef enum logic [2:0] {
    PSV_FULL, PSV_LIGHT, PSV_ACTIVE_DISC, PSV_PASSIVE_DISC, PSV_NEAR_OFF
  } psv_state_t;
  localparam logic [2:0]  PSV_CODE_FULL    = 3'h0;
  localparam logic [2:0]  PSV_CODE_LIGHT   = 3'h1;
  localparam logic [2:0]  PSV_CODE_ACTIVE  = 3'h2;
  localparam logic [2:0]  PSV_CODE_PASSIVE = 3'h3;
  localparam logic [2:0]  PSV_CODE_OFF     = 3'h4;
  localparam int          PSV_VW           = 16;     // target in 0.0625 mV units
  localparam int          PSV_CLK_MHZ      = 200;
  localparam int          PSV_TICK_NS      = 1000;   // rate step period 1 us
  localparam int          PSV_TICK_CYC     = PSV_TICK_NS * PSV_CLK_MHZ / 1000;
  localparam logic [15:0] PSV_ZERO_V       = 16'h0000;
  localparam logic [15:0] PSV_DECAY_STEP   = 16'h0010; // natural decay per us
  localparam logic [7:0]  PSV_HINT_RESET   = 8'h00;
  localparam logic [15:0] PSV_COMP_RESET   = 16'h0000;
endpackage : psv_pkg

/* File: rtl/psv_slew.sv */
// voltage target stepper driven by a 1 us tick
// assumes the rate codes are held stable by configuration
`timescale 1ns/100ps
module psv_slew
  import psv_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // control
  input  wire logic                tick,
  input  wire logic [3:0]          fast_sel,
  input  wire logic [1:0]          slow_sel,
  input  wire logic                slow_en,
  input  wire logic [PSV_VW-1:0]   setpoint,
  // state
  output logic      [PSV_VW-1:0]   target,
  output logic                     moving,
  output logic                     rising
);
  logic [PSV_VW-1:0] fast_rate;
  logic [PSV_VW-1:0] rate;
  logic [PSV_VW-1:0] next_target;

  // fast rate table in 1/16 mV per us
  always_comb begin
    case (fast_sel)
      4'h0: fast_rate = 16'h00A0;
      4'h1: fast_rate = 16'h00F0;
      4'h2: fast_rate = 16'h0140;
      4'h3: fast_rate = 16'h0190;
      4'h4: fast_rate = 16'h01E0;
      4'h5: fast_rate = 16'h0230;
      4'h6: fast_rate = 16'h0280;
      4'h7: fast_rate = 16'h02D0;
      4'h8: fast_rate = 16'h0320;
      4'h9: fast_rate = 16'h0370;
      4'hA: fast_rate = 16'h03C0;
      4'hB: fast_rate = 16'h0410;
      4'hC: fast_rate = 16'h0460;
      4'hD: fast_rate = 16'h0500;
      4'hE: fast_rate = 16'h0550;
      default: fast_rate = 16'h05F0;
    endcase
  end

  // divide by 2, 4, 8 or 16
  always_comb begin
    rate = slow_en ? (fast_rate >> (slow_sel + 2'h1) ) : fast_rate;
    if (slow_en && slow_sel == 2'h3) begin
      rate = fast_rate >> 4;
    end
  end

  always_comb begin
    next_target = target;
    if (setpoint > target) begin
      next_target = (setpoint - target > rate) ? PSV_VW'(target + rate) : setpoint;
    end else if (setpoint < target) begin
      next_target = (target - setpoint > rate) ? PSV_VW'(target - rate) : setpoint;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target <= '0;
      moving <= 1'b0;
      rising <= 1'b0;
    end else begin
      moving <= (setpoint != target);
      rising <= (setpoint > target);
      if (tick) begin
        target <= next_target;
      end
    end
  end

  a_slew_no_overshoot: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && setpoint >= target) |=> (target <= $past(setpoint)))
    else $error("slew target passed setpoint");
endmodule : psv_slew

/* File: rtl/psv_ctrl.sv */
// power state sequencer with slew and ramp correction
// assumes command strobes are one-cycle pulses decoded upstream, synchronous to CLOCK
`timescale 1ns/100ps
module psv_ctrl
  import psv_pkg::*;
(
  // clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  // configuration
  input  wire logic [3:0]        FAST_RATE_SEL,
  input  wire logic [1:0]        SLOW_RATE_SEL,
  input  wire logic              SLOW_RATE_EN,
  input  wire logic              AUTO_MODE,
  input  wire logic              PHASE_SHED_EN,
  input  wire logic              MULTI_RAIL,
  input  wire logic              DEEP_STATE_RAMP_SELECT,
  input  wire logic              LOAD_LINE_POSITIONING,
  input  wire logic [7:0]        OUT_CAP_TERM,
  input  wire logic [7:0]        POS_BANDWIDTH_TERM,
  input  wire logic [7:0]        DISCONTINUOUS_ENTRY_CURRENT,
  input  wire logic              AUTO_PASSIVE,
  // regulator conditions
  input  wire logic [7:0]        PHASE_CURRENT,
  input  wire logic              FSW_ABOVE_DESIRED,
  input  wire logic              CURRENT_LIMIT,
  // serial voltage id commands
  input  wire logic              SV_STATE_CMD,
  input  wire logic [2:0]        SV_STATE,
  input  wire logic              SV_SETVID_CMD,
  input  wire logic [15:0]       SV_SETVID,
  input  wire logic              SV_HINT_CMD,
  input  wire logic [7:0]        SV_HINT_DATA,
  input  wire logic              SV_CLOCK_LEVEL,
  // system bus commands
  input  wire logic              BUS_STATE_CMD,
  input  wire logic [2:0]        BUS_STATE,
  // outputs
  output logic      [2:0]        POWER_STATE,
  output logic                   SV_ACK,
  output logic      [15:0]       VOLTAGE_TARGET,
  output logic      [15:0]       RAMP_CORRECTION,
  output logic                   PWM_TRISTATE,
  output logic      [7:0]        EFFICIENCY_HINT_REGISTERS,
  output logic                   DVID_ACTIVE
);
  psv_state_t        state;
  psv_state_t        next_state;
  logic [15:0]       setpoint;
  logic [15:0]       slew_set;
  logic [15:0]       slew_target;
  logic              slew_moving;
  logic              slew_rising;
  logic [15:0]       tick_cnt;
  logic              tick;
  logic              clk_seen;
  logic [15:0]       decay_v;
  logic [15:0]       next_corr;
  logic              dvid_start;

  // 1 us enable pulse for the slew stepper
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 16'(PSV_TICK_CYC - 1));
      tick_cnt <= (tick_cnt == 16'(PSV_TICK_CYC - 1)) ? '0 : 16'(tick_cnt + 16'h0001);
    end
  end

  // previous serial clock level for toggle detection
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      clk_seen <= 1'b0;
    end else begin
      clk_seen <= SV_CLOCK_LEVEL;
    end
  end

  assign dvid_start = SV_SETVID_CMD && (SV_SETVID != setpoint);

  // state sequencer
  always_comb begin
    next_state = state;
    case (state)
      PSV_FULL: begin
        // autonomous discontinuous entry on low current
        if (AUTO_MODE && !slew_moving && PHASE_CURRENT < DISCONTINUOUS_ENTRY_CURRENT) begin
          next_state = AUTO_PASSIVE ? PSV_PASSIVE_DISC : PSV_ACTIVE_DISC;
        end
      end
      PSV_LIGHT: begin
        // return to full power on change or limit
        if (!AUTO_MODE && (dvid_start || CURRENT_LIMIT)) begin
          next_state = PSV_FULL;
        end
      end
      PSV_ACTIVE_DISC, PSV_PASSIVE_DISC: begin
        if (!AUTO_MODE && (dvid_start || CURRENT_LIMIT)) begin
          next_state = PSV_FULL;
        end
        if (AUTO_MODE && (FSW_ABOVE_DESIRED || dvid_start || CURRENT_LIMIT)) begin
          next_state = PSV_FULL;
        end
      end
      PSV_NEAR_OFF: begin
        // wake by clock toggle or set voltage
        if ((!MULTI_RAIL && SV_CLOCK_LEVEL != clk_seen) || (MULTI_RAIL && SV_SETVID_CMD)) begin
          next_state = PSV_FULL;
        end
      end
      default: next_state = PSV_FULL;
    endcase
    // commands from either port, serial wins
    if (state != PSV_NEAR_OFF && (SV_STATE_CMD || BUS_STATE_CMD)) begin
      case (SV_STATE_CMD ? SV_STATE : BUS_STATE)
        PSV_CODE_FULL:    next_state = PSV_FULL;
        PSV_CODE_LIGHT:   next_state = PSV_LIGHT;
        PSV_CODE_ACTIVE:  next_state = PSV_ACTIVE_DISC;
        PSV_CODE_PASSIVE: next_state = PSV_PASSIVE_DISC;
        // near off from serial id only
        PSV_CODE_OFF:     next_state = SV_STATE_CMD ? PSV_NEAR_OFF : next_state;
        default:          next_state = next_state;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= PSV_FULL;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      POWER_STATE  <= PSV_CODE_FULL;
      PWM_TRISTATE <= 1'b0;
    end else begin
      case (next_state)
        PSV_FULL:         POWER_STATE <= PSV_CODE_FULL;
        PSV_LIGHT:        POWER_STATE <= PSV_CODE_LIGHT;
        PSV_ACTIVE_DISC:  POWER_STATE <= PSV_CODE_ACTIVE;
        PSV_PASSIVE_DISC: POWER_STATE <= PSV_CODE_PASSIVE;
        default:          POWER_STATE <= PSV_CODE_OFF;
      endcase
      // all phases tristated in near off
      PWM_TRISTATE <= (next_state == PSV_NEAR_OFF);
    end
  end

  // acknowledge state, voltage and hint commands
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      SV_ACK <= 1'b0;
    end else begin
      SV_ACK <= SV_STATE_CMD || SV_SETVID_CMD || SV_HINT_CMD;
    end
  end

  // hint payload stored only, read by nothing else
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      EFFICIENCY_HINT_REGISTERS <= PSV_HINT_RESET;
    end else if (SV_HINT_CMD) begin
      EFFICIENCY_HINT_REGISTERS <= SV_HINT_DATA;
    end
  end

  // setpoint latch; near off drives the target to zero
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      setpoint <= PSV_ZERO_V;
    end else if (SV_SETVID_CMD) begin
      setpoint <= SV_SETVID;
    end
  end

  // ramp to zero or let it decay
  assign slew_set = (state == PSV_NEAR_OFF && DEEP_STATE_RAMP_SELECT) ? PSV_ZERO_V : setpoint;

  // decay model, only used when the ramp is not selected
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      decay_v <= PSV_ZERO_V;
    end else if (state != PSV_NEAR_OFF) begin
      decay_v <= slew_target;
    end else if (tick) begin
      decay_v <= (decay_v > PSV_DECAY_STEP) ? 16'(decay_v - PSV_DECAY_STEP) : PSV_ZERO_V;
    end
  end

  psv_slew u_slew (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .tick     (tick),
    .fast_sel (FAST_RATE_SEL),
    .slow_sel (SLOW_RATE_SEL),
    .slow_en  (SLOW_RATE_EN),
    .setpoint (slew_set),
    .target   (slew_target),
    .moving   (slew_moving),
    .rising   (slew_rising)
  );

  // correction during an upward ramp, capacitance times bandwidth
  always_comb begin
    next_corr = PSV_COMP_RESET;
    if (LOAD_LINE_POSITIONING && slew_moving && slew_rising) begin
      next_corr = 16'(OUT_CAP_TERM * POS_BANDWIDTH_TERM);
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      VOLTAGE_TARGET  <= PSV_ZERO_V;
      RAMP_CORRECTION <= PSV_COMP_RESET;
      DVID_ACTIVE     <= 1'b0;
    end else begin
      VOLTAGE_TARGET  <= (state == PSV_NEAR_OFF && !DEEP_STATE_RAMP_SELECT) ? decay_v : slew_target;
      RAMP_CORRECTION <= next_corr;
      DVID_ACTIVE     <= slew_moving;
    end
  end

  // assertions
  a_bus_no_deep: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (BUS_STATE_CMD && !SV_STATE_CMD && state != PSV_NEAR_OFF) |=> state != PSV_NEAR_OFF)
    else $error("bus command entered near off");
  a_hint_ack: assert property (@(posedge CLOCK) disable iff (!RST_N)
    SV_HINT_CMD |=> (SV_ACK && EFFICIENCY_HINT_REGISTERS == $past(SV_HINT_DATA)))
    else $error("hint write not acked or stored");
  a_no_auto_light: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state != PSV_LIGHT && !SV_STATE_CMD && !BUS_STATE_CMD) |=> state != PSV_LIGHT)
    else $error("light load entered without command");
  // auto mode with shedding on has no autonomous way out of light load
  a_light_hold: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state == PSV_LIGHT && AUTO_MODE && PHASE_SHED_EN &&
     !SV_STATE_CMD && !BUS_STATE_CMD) |=> state == PSV_LIGHT)
    else $error("light load left without command");
  a_limit_exit: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (CURRENT_LIMIT && !SV_STATE_CMD && !BUS_STATE_CMD &&
     (state == PSV_ACTIVE_DISC || state == PSV_PASSIVE_DISC)) |=> state == PSV_FULL)
    else $error("current limit did not restore full power");
  a_auto_fsw_exit: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (AUTO_MODE && FSW_ABOVE_DESIRED && !SV_STATE_CMD && !BUS_STATE_CMD &&
     state == PSV_ACTIVE_DISC) |=> state == PSV_FULL)
    else $error("frequency exit missed");
  a_wake_toggle: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state == PSV_NEAR_OFF && !MULTI_RAIL && SV_CLOCK_LEVEL != clk_seen) |=> state == PSV_FULL)
    else $error("clock toggle did not wake");
  a_deep_tristate: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state == PSV_NEAR_OFF) |-> PWM_TRISTATE)
    else $error("phases not tristated in near off");
  a_auto_entry: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state == PSV_FULL && AUTO_MODE && !slew_moving && !SV_STATE_CMD && !BUS_STATE_CMD &&
     PHASE_CURRENT < DISCONTINUOUS_ENTRY_CURRENT) |=> (state == PSV_ACTIVE_DISC || state == PSV_PASSIVE_DISC))
    else $error("low current did not enter discontinuous");
  a_corr_down: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (!slew_rising || !LOAD_LINE_POSITIONING) |=> RAMP_CORRECTION == PSV_COMP_RESET)
    else $error("correction outside an upward ramp");
endmodule : psv_ctrl

/* File: tb/psv_host.sv */
// far side model: serial voltage id host and system bus master
// assumes strobes sampled on the rising clk edge
`timescale 1ns/100ps
module psv_host (
  // clock
  input  wire logic        clk,
  // serial voltage id side
  output logic             sv_state_cmd,
  output logic [2:0]       sv_state,
  output logic             sv_setvid_cmd,
  output logic [15:0]      sv_setvid,
  output logic             sv_hint_cmd,
  output logic [7:0]       sv_hint_data,
  output logic             sv_clock_level,
  // system bus side
  output logic             bus_state_cmd,
  output logic [2:0]       bus_state
);
  // idle: strobes low, serial clock parked between frames
  initial begin
    {sv_state_cmd, sv_setvid_cmd, sv_hint_cmd, bus_state_cmd} = 4'h0;
    {sv_state, sv_setvid, sv_hint_data, bus_state} = 30'h0;
    sv_clock_level = 1'b0;
  end
  // one-cycle command: kind 0 state, 1 voltage, 2 hint, 3 bus state
  // near off asked on the bus only when told to
  task automatic send(input logic [1:0] kind, input logic [15:0] val);
    @(posedge clk);
    #1;
    {sv_state, sv_setvid, sv_hint_data, bus_state} = {val[2:0], val, val[7:0], val[2:0]};
    case (kind)
      2'h0: sv_state_cmd = 1'b1;
      2'h1: sv_setvid_cmd = 1'b1;
      2'h2: sv_hint_cmd = 1'b1;
      default: bus_state_cmd = 1'b1;
    endcase
    @(posedge clk);
    #1;
    {sv_state_cmd, sv_setvid_cmd, sv_hint_cmd, bus_state_cmd} = 4'h0;
    // payload inverted after release so a stale value never passes
    {sv_state, sv_setvid, sv_hint_data, bus_state} = ~{sv_state, sv_setvid, sv_hint_data, bus_state};
  endtask : send
  task automatic toggle_clock();
    @(posedge clk);
    #1;
    sv_clock_level = ~sv_clock_level;
  endtask : toggle_clock
endmodule : psv_host

/* File: tb/tb_top.sv */
// self-checking bench for psv_ctrl, link commands through psv_host
// assumes inputs change and outputs are read 1 ns after clk rises
`timescale 1ns/100ps
module tb_top;
  import psv_pkg::*;
  // fast slew rates in mV/us by code
  localparam logic [6:0] MV [16] = '{7'h0A, 7'h0F, 7'h14, 7'h19, 7'h1E, 7'h23, 7'h28, 7'h2D,
                                     7'h32, 7'h37, 7'h3C, 7'h41, 7'h46, 7'h50, 7'h55, 7'h5F};
  logic        clk, rst_n, slow_en, auto_m, shed, multi, ramp_sel, llp, passive, fsw, ilim;
  logic        s_cmd, v_cmd, h_cmd, sclk, b_cmd, ack, pwm_off, dvid;
  logic [3:0]  fast;
  logic [1:0]  slow;
  logic [2:0]  s_st, b_st, ps;
  logic [7:0]  cap, bw, ni, cur, h_dat, hint;
  logic [15:0] s_vid, vt, rc, v0;
  int          n_mismatch, n_compared, n;

  psv_host i_host (.clk(clk), .sv_state_cmd(s_cmd), .sv_state(s_st), .sv_setvid_cmd(v_cmd),
    .sv_setvid(s_vid), .sv_hint_cmd(h_cmd), .sv_hint_data(h_dat), .sv_clock_level(sclk),
    .bus_state_cmd(b_cmd), .bus_state(b_st));
  psv_ctrl i_dut (.CLOCK(clk), .RST_N(rst_n), .FAST_RATE_SEL(fast), .SLOW_RATE_SEL(slow),
    .SLOW_RATE_EN(slow_en), .AUTO_MODE(auto_m), .PHASE_SHED_EN(shed), .MULTI_RAIL(multi),
    .DEEP_STATE_RAMP_SELECT(ramp_sel), .LOAD_LINE_POSITIONING(llp), .OUT_CAP_TERM(cap),
    .POS_BANDWIDTH_TERM(bw), .DISCONTINUOUS_ENTRY_CURRENT(ni), .AUTO_PASSIVE(passive),
    .PHASE_CURRENT(cur), .FSW_ABOVE_DESIRED(fsw), .CURRENT_LIMIT(ilim), .SV_STATE_CMD(s_cmd),
    .SV_STATE(s_st), .SV_SETVID_CMD(v_cmd), .SV_SETVID(s_vid), .SV_HINT_CMD(h_cmd),
    .SV_HINT_DATA(h_dat), .SV_CLOCK_LEVEL(sclk), .BUS_STATE_CMD(b_cmd), .BUS_STATE(b_st),
    .POWER_STATE(ps), .SV_ACK(ack), .VOLTAGE_TARGET(vt), .RAMP_CORRECTION(rc),
    .PWM_TRISTATE(pwm_off), .EFFICIENCY_HINT_REGISTERS(hint), .DVID_ACTIVE(dvid));

  // compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // counts, verdict, end of run
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // land 1 ns after the n-th next rising edge
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  // bounded wait for a state; running out ends the run
  task automatic wait_ps(input logic [2:0] exp, input int lim);
    for (int i = 0; i < lim && ps !== exp; i++)
      step(1);
    chk("power state", {13'h0, ps}, {13'h0, exp});
    if (ps !== exp)
      results();
  endtask : wait_ps
  // bounded wait until target equals v (eq) or leaves v (!eq)
  task automatic wait_vt(input logic [15:0] v, input bit eq, input int lim, output int k);
    for (k = 0; k < lim && ((vt === v) != eq); k++)
      step(1);
    if (k == lim) begin
      n_mismatch++;
      $display("FAIL target wait expected %h seen %h", v, vt);
      results();
    end
  endtask : wait_vt
  // two-step ramp: step size, tick spacing, then hold
  task automatic ramp(input logic [3:0] f, input logic e, input logic [1:0] s);
    logic [15:0] st, r;
    {fast, slow_en, slow} = {f, e, s};
    st = vt;
    r = {5'h0, MV[f], 4'h0} >> (e ? int'(s) + 1 : 0);
    i_host.send(2'h1, 16'(st + 2 * r));
    wait_vt(st, 1'b0, 260, n);
    chk("first step", vt, 16'(st + r));
    chk("correction", rc, llp ? {8'h0, cap} * {8'h0, bw} : 16'h0);
    wait_vt(16'(st + r), 1'b0, 260, n);
    chk("step spacing", 16'(n), 16'h00C8);
    step(250);
    chk("hold", vt, 16'(st + 2 * r));
  endtask : ramp

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // main sequence
  initial begin
    {rst_n, slow_en, auto_m, multi, passive, fsw, ilim} = 7'h0;
    {shed, ramp_sel, llp, fast, slow} = 9'h1C0;
    {cap, bw, ni, cur} = 32'h0305_1040;
    {n_mismatch, n_compared} = {32'h0, 32'h0};
    step(12);
    chk("reset", {2'h0, ps, ack, pwm_off, dvid, hint}, 16'h0);
    rst_n = 1'b1;
    // command mode via link and bus
    i_host.send(2'h0, 16'h0001);
    chk("light by link", {12'h0, ack, ps}, {12'h0, 1'b1, PSV_CODE_LIGHT});
    step(1);
    chk("ack one cycle", {15'h0, ack}, 16'h0000);
    ilim = 1'b1;
    wait_ps(PSV_CODE_FULL, 4);
    ilim = 1'b0;
    i_host.send(2'h3, 16'h0002);
    wait_ps(PSV_CODE_ACTIVE, 2);
    i_host.send(2'h3, 16'h0004);
    step(2);
    chk("bus near off", {12'h0, pwm_off, ps}, {12'h0, 1'b0, PSV_CODE_ACTIVE});
    i_host.send(2'h0, 16'h0003);
    i_host.send(2'h0, 16'h0001);
    wait_ps(PSV_CODE_LIGHT, 2);
    i_host.send(2'h0, 16'h0000);
    wait_ps(PSV_CODE_FULL, 2);
    i_host.send(2'h0, 16'h0002);
    i_host.send(2'h1, 16'h0040);
    wait_ps(PSV_CODE_FULL, 3);
    // busy flag follows the setpoint two edges later
    step(2);
    chk("dvid busy", {15'h0, dvid}, 16'h0001);
    wait_vt(16'h0040, 1'b1, 400, n);
    // hints stored, regulation untouched
    i_host.send(2'h2, 16'h00A5);
    chk("hint store", {7'h0, ack, hint}, 16'h01A5);
    chk("hint inert", vt, 16'h0040);
    // every fast rate, then every divider
    for (int i = 0; i < 16; i++)
      ramp(4'(i), 1'b0, 2'h0);
    llp = 1'b0;
    for (int i = 0; i < 4; i++)
      ramp(4'hF, 1'b1, 2'(i));
    // auto mode entries and exits
    {auto_m, passive, cur} = 10'h208;
    wait_ps(PSV_CODE_ACTIVE, 8);
    fsw = 1'b1;
    wait_ps(PSV_CODE_FULL, 4);
    {fsw, passive} = 2'h1;
    wait_ps(PSV_CODE_PASSIVE, 8);
    ilim = 1'b1;
    wait_ps(PSV_CODE_FULL, 4);
    ilim = 1'b0;
    wait_ps(PSV_CODE_PASSIVE, 8);
    // commanded light load holds in auto mode while shedding is on
    i_host.send(2'h0, 16'h0001);
    {fsw, ilim} = 2'h3;
    step(3);
    chk("auto light holds", {13'h0, ps}, {13'h0, PSV_CODE_LIGHT});
    {fsw, ilim} = 2'h0;
    i_host.send(2'h0, 16'h0003);
    wait_ps(PSV_CODE_PASSIVE, 2);
    i_host.send(2'h1, vt + 16'h0010);
    wait_ps(PSV_CODE_FULL, 3);
    {auto_m, cur, slow_en} = 10'h080;
    // near off: entry, ramp down, refused commands, clock toggle wake
    i_host.send(2'h0, 16'h0004);
    chk("near off", {11'h0, ack, pwm_off, ps}, 16'h001C);
    wait_vt(16'h0000, 1'b1, 4400, n);
    i_host.send(2'h0, 16'h0000);
    i_host.send(2'h3, 16'h0000);
    step(2);
    chk("stay off", {13'h0, ps}, {13'h0, PSV_CODE_OFF});
    i_host.toggle_clock();
    wait_ps(PSV_CODE_FULL, 3);
    chk("phases driven", {15'h0, pwm_off}, 16'h0000);
    // decay path: the output drops one decay step per tick
    {multi, ramp_sel} = 2'h2;
    step(250);
    i_host.send(2'h0, 16'h0004);
    step(1);
    v0 = vt;
    wait_vt(v0, 1'b0, 260, n);
    chk("decay step", vt, 16'(v0 - PSV_DECAY_STEP));
    i_host.toggle_clock();
    step(3);
    chk("multi stays off", {13'h0, ps}, {13'h0, PSV_CODE_OFF});
    i_host.send(2'h1, 16'h0100);
    wait_ps(PSV_CODE_FULL, 3);
    results();
  end
endmodule : tb_top
